/* verilog/deos_pkg.sv */
/*
 * shared constants and types of the drive enable and output select block:
 * register offsets, field positions, reset values, output codes, timing.
 * assumes a 32-bit AXI4-Lite master and a 50 MHz clock.
 */
package deos_pkg;

    // ----------------------------------------------------------------
    // bus
    // ----------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CMD = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_RATED = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_RUN = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_ENGAGE = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_RELEASE = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_OUTSEL = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_FUNC = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_REPLY = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_MODE = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_WINDOW = 6'h28;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CMD_DIS_BIT = 0;
    localparam int CMD_EN_BIT = 1;
    localparam int CMD_MODEL_BIT = 2;
    localparam int OUTSEL_PT_LSB = 4;
    localparam int FUNC_ALARM_BIT = 0;
    localparam int FUNC_BRAKE_BIT = 1;
    localparam int FUNC_ASEL_LSB = 4;
    localparam int FUNC_GP_LSB = 8;
    localparam int FUNC_OWN_LSB = 12;
    localparam int REPLY_VALID_BIT = 8;

    // ----------------------------------------------------------------
    // reset values and limits (current in 0.01 A)
    // ----------------------------------------------------------------
    localparam logic [9:0] CEIL_LO = 10'h258;
    localparam logic [9:0] CEIL_HI = 10'h3E8;
    localparam logic [9:0] RST_RATED = 10'h064;
    localparam logic [9:0] RST_RUN = 10'h032;
    localparam logic [15:0] RST_DELAY = 16'h0000;
    localparam logic [15:0] RST_WINDOW = 16'h000A;
    localparam logic [3:0] RST_ALARM_SEL = 4'h3;
    localparam logic [3:0] RST_MODE = 4'h0;

    // ----------------------------------------------------------------
    // output select codes and reply characters
    // ----------------------------------------------------------------
    localparam logic [3:0] MO_STILL_CLOSE = 4'h1;
    localparam logic [3:0] MO_STILL_OPEN = 4'h2;
    localparam logic [3:0] MO_FREE = 4'h3;
    localparam logic [3:0] MO_TACH_LO = 4'h4;
    localparam logic [3:0] MO_TACH_HI = 4'h8;
    localparam logic [3:0] MO_INPOS_CLOSE = 4'h9;
    localparam logic [3:0] MO_INPOS_OPEN = 4'hA;
    localparam logic [3:0] ALARM_SEL_OPEN = 4'h2;
    localparam logic [4:0] TACH_HALF_MAX = 5'h10;
    localparam logic [7:0] CH_REFUSED = 8'h26;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int DELAY_UNIT_NS = 1000000;
    localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SEQ_OFF, SEQ_RELEASE, SEQ_ON, SEQ_ENGAGE} deos_seq_e;
    typedef enum logic [2:0] {OWN_MOTION, OWN_TACH, OWN_ALARM, OWN_BRAKE, OWN_GP} deos_own_e;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } deos_axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } deos_axil_rsp_s;

endpackage : deos_pkg

/* verilog/deos_drive_ctrl.sv */
/*
 * drive enable sequencing, current ceiling, reply characters and the
 * selection of the function carried by the motion-status output.
 * assumes an AXI4-Lite master on one 50 MHz clock and synchronous inputs.
 */
`timescale 1ns/100ps

module deos_drive_ctrl
#(
    parameter bit IS_SERVO = 1'b0,
    parameter bit FLEX_IO = 1'b0,
    parameter logic [9:0] CEIL_CA = deos_pkg::CEIL_HI,
    parameter logic [7:0] MODEL_CODE = 8'h41, // arbitrary value
    parameter int DELAY_UNIT_CYC = deos_pkg::DELAY_UNIT_CYCLES
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire deos_pkg::deos_axil_req_s axi_req,
    output deos_pkg::deos_axil_rsp_s axi_rsp,
    input wire logic enable_blocked,
    input wire logic motor_moving,
    input wire logic drive_fault,
    input wire logic motion_tick,
    input wire logic [15:0] pos_err_mag,
    input wire logic [3:0] io_is_output,
    output logic motor_current_on,
    output logic [9:0] current_cmd,
    output logic [9:0] probe_limit,
    output logic brake_out,
    output logic [3:0] active_mode,
    output logic [3:0] out_closed
);
    import deos_pkg::*;

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    if (CEIL_CA != CEIL_LO && CEIL_CA != CEIL_HI)
    begin : g_bad_ceil
        $error("ceiling must be 6.00 A or 10.00 A");
    end
    if (DELAY_UNIT_CYC < 1 || DELAY_UNIT_CYC > 65535)
    begin : g_bad_unit
        $error("delay unit must be 1 to 65535 cycles");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        deos_axil_rsp_s rsp;
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        deos_seq_e seq;
        logic [15:0] unit_cnt;
        logic [15:0] dly_cnt;
        logic [9:0] rated;
        logic [9:0] run_req;
        logic [15:0] engage_dly;
        logic [15:0] release_dly;
        logic [3:0] mode;
        logic [15:0] window;
        logic [3:0] mo_code;
        logic [2:0] mo_point;
        deos_own_e owner;
        logic [3:0] alarm_sel;
        logic [3:0] gp;
        logic [7:0] reply;
        logic reply_valid;
        logic [4:0] tach_cnt;
        logic tach;
        logic cur_on;
        logic [9:0] cur_cmd;
        logic [9:0] probe;
        logic brake;
        logic [3:0] act_mode;
        logic [3:0] closed;
    } deos_state_s;

    deos_state_s s_q;
    deos_state_s s_d;

    function automatic logic [31:0] deos_merge(input logic [31:0] old,
                                               input logic [31:0] d,
                                               input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (d & m);
    endfunction : deos_merge

    function automatic logic [9:0] deos_min(input logic [9:0] a, input logic [9:0] b);
        return (a < b) ? a : b;
    endfunction : deos_min

    function automatic logic deos_mapped(input logic [ADDR_W-1:0] a);
        return a == OFS_CMD || a == OFS_RATED || a == OFS_RUN || a == OFS_ENGAGE
            || a == OFS_RELEASE || a == OFS_OUTSEL || a == OFS_FUNC
            || a == OFS_STATUS || a == OFS_REPLY || a == OFS_MODE || a == OFS_WINDOW;
    endfunction : deos_mapped

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic do_wr;
        logic [31:0] wv;
        logic [31:0] rv;
        logic cmd_dis;
        logic cmd_en;
        logic cmd_model;
        logic code_ok;
        logic [3:0] c;
        logic [2:0] p;
        logic [1:0] tgt;
        logic in_pos;
        logic owned;
        logic unit_tick;
        do_wr = 1'b0;
        wv = 32'h0000_0000;
        rv = 32'h0000_0000;
        cmd_dis = 1'b0;
        cmd_en = 1'b0;
        cmd_model = 1'b0;
        code_ok = 1'b0;
        c = 4'h0;
        p = 3'h0;
        tgt = 2'h0;
        in_pos = 1'b0;
        owned = 1'b0;
        unit_tick = 1'b0;
        s_d = s_q;

        // bus: response hand-backs first, so a new event below wins
        if (s_q.rsp.bvalid && axi_req.bready)
        begin
            s_d.rsp.bvalid = 1'b0;
        end
        if (s_q.rsp.rvalid && axi_req.rready)
        begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (axi_req.awvalid && s_q.rsp.awready)
        begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_q.rsp.wready)
        begin
            s_d.w_got = 1'b1;
            s_d.w_data = axi_req.wdata;
            s_d.w_strb = axi_req.wstrb;
        end

        // read: reads return the stored value of each parameter, except RUN, which returns the run current clamped to the rated current
        if (axi_req.arvalid && s_q.rsp.arready)
        begin
            case (axi_req.araddr)
                OFS_RATED: rv[9:0] = s_q.rated;
                OFS_RUN: rv[9:0] = deos_min(s_q.run_req, s_q.rated);
                OFS_ENGAGE: rv[15:0] = s_q.engage_dly;
                OFS_RELEASE: rv[15:0] = s_q.release_dly;
                OFS_OUTSEL: rv[6:0] = {s_q.mo_point, s_q.mo_code};
                OFS_FUNC: rv[14:4] = {s_q.owner, s_q.gp, s_q.alarm_sel};
                OFS_STATUS: rv[3:0] = {s_q.brake, s_q.cur_on, s_q.seq};
                OFS_REPLY: rv[8:0] = {s_q.reply_valid, s_q.reply};
                OFS_MODE: rv[3:0] = s_q.mode;
                OFS_WINDOW: rv[15:0] = s_q.window;
                default: rv = 32'h0000_0000;
            endcase
            if (axi_req.araddr == OFS_REPLY)
            begin
                s_d.reply_valid = 1'b0;
            end
            s_d.rsp.rdata = rv;
            s_d.rsp.rresp = deos_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
            s_d.rsp.rvalid = 1'b1;
        end

        // write: address and data in either order, then one response
        do_wr = s_d.aw_got && s_d.w_got && !s_d.rsp.bvalid;
        if (do_wr)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = deos_mapped(s_d.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            case (s_d.aw_addr)
                OFS_CMD:
                begin
                    wv = deos_merge(32'h0000_0000, s_d.w_data, s_d.w_strb);
                    cmd_dis = wv[CMD_DIS_BIT];
                    cmd_en = wv[CMD_EN_BIT];
                    cmd_model = wv[CMD_MODEL_BIT];
                end
                OFS_RATED:
                begin
                    wv = deos_merge({22'h0, s_q.rated}, s_d.w_data, s_d.w_strb);
                    s_d.rated = deos_min(wv[9:0], CEIL_CA);
                end
                OFS_RUN:
                begin
                    wv = deos_merge({22'h0, s_q.run_req}, s_d.w_data, s_d.w_strb);
                    s_d.run_req = wv[9:0];
                end
                OFS_ENGAGE:
                begin
                    wv = deos_merge({16'h0, s_q.engage_dly}, s_d.w_data, s_d.w_strb);
                    s_d.engage_dly = wv[15:0];
                end
                OFS_RELEASE:
                begin
                    wv = deos_merge({16'h0, s_q.release_dly}, s_d.w_data, s_d.w_strb);
                    s_d.release_dly = wv[15:0];
                end
                OFS_MODE:
                begin
                    wv = deos_merge({28'h0, s_q.mode}, s_d.w_data, s_d.w_strb);
                    s_d.mode = wv[3:0];
                end
                OFS_WINDOW:
                begin
                    wv = deos_merge({16'h0, s_q.window}, s_d.w_data, s_d.w_strb);
                    s_d.window = wv[15:0];
                end
                OFS_OUTSEL:
                begin
                    wv = deos_merge({25'h0, s_q.mo_point, s_q.mo_code}, s_d.w_data,
                                    s_d.w_strb);
                    c = wv[3:0];
                    p = wv[OUTSEL_PT_LSB+:3];
                    code_ok = (c >= MO_STILL_CLOSE && c <= MO_TACH_HI)
                        || (IS_SERVO && !FLEX_IO
                            && (c == MO_INPOS_CLOSE || c == MO_INPOS_OPEN));
                    if (FLEX_IO)
                    begin
                        code_ok = code_ok && p >= 3'h1 && p <= 3'h4
                            && io_is_output[2'(p - 3'h1)];
                    end
                    if (code_ok)
                    begin
                        s_d.mo_code = c;
                        s_d.mo_point = FLEX_IO ? p : 3'h0;
                        if (c >= MO_TACH_LO && c <= MO_TACH_HI)
                        begin
                            s_d.owner = OWN_TACH;
                            s_d.tach_cnt = 5'h00;
                        end
                        else if (c != MO_FREE)
                        begin
                            s_d.owner = OWN_MOTION;
                        end
                        else if (s_q.owner == OWN_MOTION || s_q.owner == OWN_TACH)
                        begin
                            s_d.owner = OWN_GP;
                        end
                    end
                end
                OFS_FUNC:
                begin
                    wv = deos_merge({16'h0, 4'h0, s_q.gp, s_q.alarm_sel, 4'h0},
                                    s_d.w_data, s_d.w_strb);
                    s_d.gp = wv[FUNC_GP_LSB+:4];
                    s_d.alarm_sel = wv[FUNC_ASEL_LSB+:4];
                    if (wv[FUNC_ALARM_BIT] || wv[FUNC_BRAKE_BIT])
                    begin
                        s_d.owner = wv[FUNC_ALARM_BIT] ? OWN_ALARM : OWN_BRAKE;
                        if (s_q.mo_code == MO_STILL_CLOSE || s_q.mo_code == MO_STILL_OPEN)
                        begin
                            s_d.alarm_sel = MO_FREE;
                        end
                    end
                end
                default: wv = 32'h0000_0000;
            endcase
        end
        s_d.rsp.awready = !s_d.aw_got;
        s_d.rsp.wready = !s_d.w_got;
        s_d.rsp.arready = !s_d.rsp.rvalid;

        // enable sequencer
        unit_tick = s_q.unit_cnt == 16'(DELAY_UNIT_CYC - 1);
        s_d.unit_cnt = unit_tick ? 16'h0000 : s_q.unit_cnt + 16'h0001;
        case (s_q.seq)
            SEQ_RELEASE, SEQ_ENGAGE:
            begin
                if (s_q.dly_cnt == 16'h0000)
                begin
                    s_d.seq = (s_q.seq == SEQ_RELEASE) ? SEQ_ON : SEQ_OFF;
                end
                else if (unit_tick)
                begin
                    s_d.dly_cnt = s_q.dly_cnt - 16'h0001;
                end
            end
            SEQ_OFF, SEQ_ON: s_d.dly_cnt = 16'h0000;
            default: s_d.seq = SEQ_OFF;
        endcase
        if (cmd_dis)
        begin
            if (s_q.seq == SEQ_ON)
            begin
                s_d.seq = SEQ_ENGAGE;
                s_d.dly_cnt = s_q.engage_dly;
                s_d.unit_cnt = 16'h0000;
            end
            else if (s_q.seq == SEQ_RELEASE)
            begin
                s_d.seq = SEQ_OFF;
            end
        end
        else if (cmd_en)
        begin
            if (enable_blocked)
            begin
                s_d.reply = CH_REFUSED;
                s_d.reply_valid = 1'b1;
            end
            else if (s_q.seq == SEQ_OFF)
            begin
                s_d.seq = SEQ_RELEASE;
                s_d.dly_cnt = s_q.release_dly;
                s_d.unit_cnt = 16'h0000;
            end
            else if (s_q.seq == SEQ_ENGAGE)
            begin
                s_d.seq = SEQ_ON;
            end
        end
        if (cmd_model)
        begin
            s_d.reply = MODEL_CODE;
            s_d.reply_valid = 1'b1;
        end

        // tach divider
        if (motion_tick && s_d.owner == OWN_TACH)
        begin
            if (s_d.tach_cnt >= (TACH_HALF_MAX >> (s_d.mo_code - MO_TACH_LO)) - 5'h01)
            begin
                s_d.tach_cnt = 5'h00;
                s_d.tach = !s_q.tach;
            end
            else
            begin
                s_d.tach_cnt = s_d.tach_cnt + 5'h01;
            end
        end

        // outputs
        in_pos = pos_err_mag <= s_q.window;
        s_d.cur_on = s_d.seq == SEQ_ON || s_d.seq == SEQ_ENGAGE;
        s_d.brake = s_d.seq == SEQ_OFF || s_d.seq == SEQ_ENGAGE;
        s_d.cur_cmd = s_d.cur_on ? deos_min(s_d.run_req, s_d.rated) : 10'h000;
        s_d.probe = s_d.rated;
        s_d.act_mode = (s_d.seq == SEQ_ON) ? s_d.mode : RST_MODE;
        case (s_d.owner)
            OWN_MOTION:
            begin
                case (s_d.mo_code)
                    MO_STILL_CLOSE: owned = FLEX_IO ? drive_fault : !motor_moving;
                    MO_STILL_OPEN: owned = FLEX_IO ? !drive_fault : motor_moving;
                    MO_INPOS_CLOSE: owned = in_pos;
                    MO_INPOS_OPEN: owned = !in_pos;
                    default: owned = 1'b0;
                endcase
            end
            OWN_TACH: owned = s_d.tach;
            OWN_ALARM: owned = (s_d.alarm_sel == ALARM_SEL_OPEN) ? !drive_fault : drive_fault;
            OWN_BRAKE: owned = !s_d.brake;
            default: owned = 1'b0;
        endcase
        tgt = FLEX_IO ? 2'(s_d.mo_point - 3'h1) : 2'h0;
        s_d.closed = s_d.gp;
        if (s_d.owner != OWN_GP)
        begin
            s_d.closed[tgt] = owned;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            s_q <= '0;
            s_q.seq <= SEQ_OFF;
            s_q.brake <= 1'b1;
            s_q.rated <= RST_RATED;
            s_q.run_req <= RST_RUN;
            s_q.probe <= RST_RATED;
            s_q.engage_dly <= RST_DELAY;
            s_q.release_dly <= RST_DELAY;
            s_q.window <= RST_WINDOW;
            s_q.mo_code <= MO_STILL_CLOSE;
            s_q.owner <= OWN_MOTION;
            s_q.alarm_sel <= RST_ALARM_SEL;
            s_q.mode <= RST_MODE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign axi_rsp = s_q.rsp;
    assign motor_current_on = s_q.cur_on;
    assign current_cmd = s_q.cur_cmd;
    assign probe_limit = s_q.probe;
    assign brake_out = s_q.brake;
    assign active_mode = s_q.act_mode;
    assign out_closed = s_q.closed;

endmodule : deos_drive_ctrl

/* sim/deos_motor_mdl.sv */
/*
 motor side model: gives one motion tick every four clocks while moving.
 assumes the drive samples the tick on the rising clock edge.
*/
`timescale 1ns/100ps
module deos_motor_mdl
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic moving,
    output logic motion_tick
);
    logic [1:0] div_q;
    always_ff @(posedge clock)
        if (!nrst)
            div_q <= 2'h0;
        else
            div_q <= div_q + 2'h1;
    assign motion_tick = moving && div_q == 2'h3;
endmodule : deos_motor_mdl

/* sim/deos_drive_ctrl_chk.sv */
/*
 checker of the drive control ports: current sequencing and bus answers.
 assumes the default current ceiling and one clock domain.
*/
`timescale 1ns/100ps
module deos_drive_ctrl_chk
(
    input wire logic clock,
    input wire logic nrst,
    input wire deos_pkg::deos_axil_req_s axi_req,
    input wire deos_pkg::deos_axil_rsp_s axi_rsp,
    input wire logic motor_current_on,
    input wire logic [9:0] current_cmd,
    input wire logic [9:0] probe_limit,
    input wire logic brake_out,
    input wire logic [3:0] active_mode
);
    import deos_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    clamp_cur_a: assert property (current_cmd <= probe_limit)
        else $error("current above rated ceiling");
    probe_ceil_a: assert property (probe_limit <= CEIL_HI)
        else $error("probe limit above ceiling");
    off_zero_a: assert property (!motor_current_on |-> current_cmd == 10'h000)
        else $error("current while off");
    engage_hold_a: assert property ($rose(brake_out) && $past(motor_current_on)
        |-> motor_current_on)
        else $error("current dropped with brake");
    drop_brake_a: assert property ($fell(motor_current_on) |-> brake_out && $past(brake_out))
        else $error("current off before brake");
    release_first_a: assert property ($rose(motor_current_on) |-> !brake_out && !$past(brake_out))
        else $error("current on before brake release");
    mode_off_a: assert property (!motor_current_on |-> active_mode == 4'h0)
        else $error("mode shown while off");
    read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer late");
    write_done_a: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
        else $error("write answer repeated");
endmodule : deos_drive_ctrl_chk
bind deos_drive_ctrl deos_drive_ctrl_chk deos_drive_ctrl_chk_inst (.clock, .nrst, .axi_req,
    .axi_rsp, .motor_current_on, .current_cmd, .probe_limit, .brake_out, .active_mode);

/* sim/tb.sv */
/*
 testbench of the drive control block over its register bus.
 assumes a short delay unit of four clocks and a stepper variant.
*/
`timescale 1ns/100ps
module tb;
    import deos_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic blk = 1'b0;
    localparam logic [7:0] TB_MODEL = 8'h4D; // arbitrary value
    logic mov = 1'b0;
    logic flt = 1'b0;
    logic tick;
    deos_axil_req_s req = '0;
    deos_axil_rsp_s rsp;
    logic cur_on;
    logic brk;
    logic [9:0] cur_cmd;
    logic [9:0] probe;
    logic [3:0] mode;
    logic [3:0] outc;
    logic [31:0] rv;
    logic [1:0] rr;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int n;
    always #10 clock = ~clock;
    deos_drive_ctrl #(.DELAY_UNIT_CYC(4), .MODEL_CODE(TB_MODEL)) deos_drive_ctrl_inst (
        .clock(clock), .nrst(nrst),
        .axi_req(req), .axi_rsp(rsp), .enable_blocked(blk), .motor_moving(mov),
        .drive_fault(flt), .motion_tick(tick), .pos_err_mag(16'h0000), .io_is_output(4'h0),
        .motor_current_on(cur_on), .current_cmd(cur_cmd), .probe_limit(probe),
        .brake_out(brk), .active_mode(mode), .out_closed(outc));
    deos_motor_mdl deos_motor_mdl_inst (.clock(clock), .nrst(nrst), .moving(mov),
        .motion_tick(tick));
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        err_total += int'(g !== e);
        if (g !== e)
            $display("[FAIL] %s expected %h seen %h", s, e, g);
    endtask : chk
    task wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        forever
        begin
            @(posedge clock);
            if (rsp.awready)
                req.awvalid <= 1'b0;
            if (rsp.wready)
                req.wvalid <= 1'b0;
            if (rsp.bvalid)
                break;
        end
        req.bready <= 1'b0;
    endtask : wr
    task rd(input logic [5:0] a);
        @(posedge clock);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        forever
        begin
            @(posedge clock);
            if (rsp.arready)
                req.arvalid <= 1'b0;
            if (rsp.rvalid)
                break;
        end
        rv = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        rd(OFS_RATED);
        chk("rated reset", 32'h64, rv);
        chk("probe reset", 32'h64, {22'h0, probe});
        wr(OFS_RATED, 32'h3FF);
        rd(OFS_RATED);
        chk("rated clamp", 32'h3E8, rv);
        chk("probe limit", 32'h3E8, {22'h0, probe});
        rd(6'h3C);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    endtask : t_regs
    task t_enable;
        wr(OFS_RATED, 32'h64);
        wr(OFS_RUN, 32'h3FF);
        wr(OFS_MODE, 32'h5);
        wr(OFS_RELEASE, 32'h2);
        wr(OFS_CMD, 32'h2);
        chk("brake on enable", 32'h0, {31'h0, brk});
        repeat (8) @(posedge clock);
        chk("current early", 32'h0, {31'h0, cur_on});
        @(posedge clock);
        chk("current on", 32'h1, {31'h0, cur_on});
        chk("current clamp", 32'h64, {22'h0, cur_cmd});
        chk("mode resumed", 32'h5, {28'h0, mode});
    endtask : t_enable
    task t_disable;
        wr(OFS_ENGAGE, 32'h3);
        wr(OFS_CMD, 32'h1);
        chk("brake on disable", 32'h1, {31'h0, brk});
        repeat (12) @(posedge clock);
        chk("current held", 32'h1, {31'h0, cur_on});
        @(posedge clock);
        chk("current off", 32'h0, {22'h0, cur_cmd});
    endtask : t_disable
    task t_reply;
        blk <= 1'b1;
        wr(OFS_CMD, 32'h2);
        rd(OFS_REPLY);
        chk("refused reply", {24'h1, CH_REFUSED}, rv);
        chk("stays off", 32'h0, {31'h0, cur_on});
        blk <= 1'b0;
        wr(OFS_CMD, 32'h4);
        rd(OFS_REPLY);
        chk("model reply", {24'h1, TB_MODEL}, rv);
    endtask : t_reply
    task t_outsel;
        wr(OFS_OUTSEL, 32'h1);
        chk("still closed", 32'h1, {31'h0, |outc});
        wr(OFS_OUTSEL, 32'h2);
        chk("still open", 32'h0, {31'h0, |outc});
        wr(OFS_OUTSEL, 32'h9);
        rd(OFS_OUTSEL);
        chk("bad code", 32'h2, rv & 32'hF);
        wr(OFS_FUNC, 32'h1);
        rd(OFS_FUNC);
        chk("alarm takeover", 32'h2030, rv & 32'h70F0);
        flt <= 1'b1;
        repeat (2) @(posedge clock);
        chk("alarm on fault", 32'h1, {31'h0, outc[0]});
        flt <= 1'b0;
        wr(OFS_OUTSEL, 32'h8);
        mov <= 1'b1;
        n = 0;
        repeat (40)
        begin
            @(posedge clock);
            #1 n += int'(outc[0] != rv[0]);
            rv[0] = outc[0];
        end
        chk("tach toggles", 32'd10, n);
        rd(OFS_FUNC);
        chk("tach owner", 32'h1000, rv & 32'h7000);
        wr(OFS_OUTSEL, 32'h3);
        rd(OFS_FUNC);
        chk("freed owner", 32'h4000, rv & 32'h7000);
    endtask : t_outsel
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    always @(posedge clock)
    begin
        cyc++;
        err_total += int'(cyc == 4000);
        if (cyc == 4000)
            tally_and_finish();
    end
    initial
    begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        t_regs();
        t_enable();
        t_disable();
        t_reply();
        t_outsel();
        tally_and_finish();
    end
endmodule : tb
